// >>> wlhssp_regs.svh
// Operation
// - Words are 16 or 32 bits, byte order selectable in both sizes
// - Little-endian byte order by default, big-endian selectable
// - Each transaction opens with a 32-bit command word from the host
// - Serial clock runs at up to 48 MHz, never faster
// - One transfer carries at most 2 KB of payload
// - Host shifts on falling edges, device captures on the active edge
// - Device drives read data before the host's first sampling rising edge
// - Last edge of the delay word launches the first read data bit
// - Standalone read: select high between command and data, gap free
// - Device inserts a fixed configured delay before backplane reads, or all reads when set; standalone reads skip it
// - Transmit edge configurable: opposite or same edge as receive
// - Serial mode chosen by levels sampled on the interface straps
// - Three functions: control 32B, backplane 64B, packet 512B
// - Packet function write data moves through the DMA path
// - Host interrupt can be routed to a general-purpose pin instead
// - Optional status word after each transaction reports errors and state
// - Response delay in units of 8 bit-times, reset value four
// - Word-length bit: clear is 16-bit, set is 32-bit, resets clear
`ifndef WLHSSP_REGS_SVH
`define WLHSSP_REGS_SVH
// ----------------------------------------
// Command word fields
// ----------------------------------------
`define WLHSSP_CMD_BITS      32
`define WLHSSP_CMD_WR_BIT    31
`define WLHSSP_CMD_INC_BIT   30
`define WLHSSP_CMD_FN_HI     29
`define WLHSSP_CMD_FN_LO     28
`define WLHSSP_CMD_AD_HI     27
`define WLHSSP_CMD_AD_LO     11
`define WLHSSP_CMD_LN_HI     10
`define WLHSSP_CMD_LN_LO     0
// ----------------------------------------
// Size limits in bytes
// ----------------------------------------
`define WLHSSP_FRAME_MAX     12'h800
`define WLHSSP_CTRL_MAX      12'h020
`define WLHSSP_BKPL_MAX      12'h040
`define WLHSSP_PKT_MAX       12'h200
// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define WLHSSP_ST_NOTAVAIL   0
`define WLHSSP_ST_UNDER      1
`define WLHSSP_ST_OVER       2
// ----------------------------------------
// Configuration reset values
// ----------------------------------------
`define WLHSSP_WLEN_RST      1'b0
`define WLHSSP_BIGE_RST      1'b0
`define WLHSSP_HISPD_RST     1'b1
`define WLHSSP_IRQPOL_RST    1'b1
`define WLHSSP_STEN_RST      1'b1
`define WLHSSP_DLYALL_RST    1'b0
`define WLHSSP_IRQGPIO_RST   1'b0
`define WLHSSP_RDLY_RST      8'h04
`define WLHSSP_DLY_UNIT_LOG2 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define WLHSSP_SCLK_MAX_MHZ  48
`define WLHSSP_SYS_MHZ       25
`endif

// >>> wlhssp_pkg.sv
`default_nettype none
package wlhssp_pkg;
  // Link phases, one-hot
  typedef enum logic [5:0] {
    PH_IDLE   = 6'b000001,
    PH_CMD    = 6'b000010,
    PH_WDATA  = 6'b000100,
    PH_DELAY  = 6'b001000,
    PH_RDATA  = 6'b010000,
    PH_STATUS = 6'b100000
  } wlhssp_phase_t;
  // Function numbers
  typedef enum logic [1:0] {
    FN_CTRL = 2'h0,
    FN_BKPL = 2'h1,
    FN_PKT  = 2'h2,
    FN_RSVD = 2'h3
  } wlhssp_fn_t;
  // Byte order between wire and word; an involution, so used both ways
  function automatic logic [31:0] wlhssp_swz(input logic [31:0] w, input logic big, input logic wide);
    if (big)
      return w;
    else if (wide)
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
    else
      return {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction
endpackage
`default_nettype wire

// >>> wlhssp_sync.sv
`default_nettype none
module wlhssp_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  // Two stages; only the second reads the first
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
endmodule // wlhssp_sync
`default_nettype wire

// >>> wlhssp_port.sv
`include "wlhssp_regs.svh"
`default_nettype none
module wlhssp_port #(
  parameter logic [2:0] STRAP_SPI = 3'h1,
  parameter int         MAX_FRAME = 2048
) (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Serial link pins
  input  wire logic        spiClk,
  input  wire logic        spiCs_b,
  input  wire logic        serial_data_in,
  output var  logic        spiSdo,
  output var  logic        spiSdoOe,
  // Straps and mode
  input  wire logic [2:0]  strapIfc,
  output var  logic        spiModeEn,
  // Configuration
  input  wire logic        cfgWr,
  input  wire logic        cfgWordLen,
  input  wire logic        cfgBigEnd,
  input  wire logic        cfgHiSpeed,
  input  wire logic        cfgIrqPol,
  input  wire logic        cfgStatEn,
  input  wire logic        cfgDelayAll,
  input  wire logic        cfgIrqGpio,
  input  wire logic [7:0]  cfgRespDelay,
  // Read requests
  output var  logic        rdReq,
  output var  logic [16:0] rdAddr,
  output var  logic [1:0]  rdFunc,
  input  wire logic [31:0] rdData,
  input  wire logic [31:0] statusIn,
  // Write words
  output var  logic        wrValid,
  output var  logic        dmaWrValid,
  output var  logic [16:0] wrAddr,
  output var  logic [1:0]  wrFunc,
  output var  logic [31:0] wrData,
  // Interrupts
  input  wire logic        devIrq,
  output var  logic        hostIrq,
  output var  logic        gpioIrq
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (MAX_FRAME < 512 || MAX_FRAME > 2048)
    $error("MAX_FRAME out of range");
  if (`WLHSSP_SYS_MHZ * 2 < `WLHSSP_SCLK_MAX_MHZ / 2)
    $error("system clock too slow for link");
  localparam logic [11:0] FRAME_LIM = 12'(MAX_FRAME);
  // ----------------------------------------
  // System-side configuration
  // ----------------------------------------
  logic       wordLen_ff, bigEnd_ff, hiSpeed_ff, irqPol_ff;
  logic       statEn_ff, delayAll_ff, irqGpio_ff;
  logic [7:0] respDelay_ff;
  // Loaded from the ports on a write strobe
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      wordLen_ff   <= `WLHSSP_WLEN_RST;
      bigEnd_ff    <= `WLHSSP_BIGE_RST;
      hiSpeed_ff   <= `WLHSSP_HISPD_RST;
      irqPol_ff    <= `WLHSSP_IRQPOL_RST;
      statEn_ff    <= `WLHSSP_STEN_RST;
      delayAll_ff  <= `WLHSSP_DLYALL_RST;
      irqGpio_ff   <= `WLHSSP_IRQGPIO_RST;
      respDelay_ff <= `WLHSSP_RDLY_RST;
    end
    else if (cfgWr)
    begin
      wordLen_ff   <= cfgWordLen;
      bigEnd_ff    <= cfgBigEnd;
      hiSpeed_ff   <= cfgHiSpeed;
      irqPol_ff    <= cfgIrqPol;
      statEn_ff    <= cfgStatEn;
      delayAll_ff  <= cfgDelayAll;
      irqGpio_ff   <= cfgIrqGpio;
      respDelay_ff <= cfgRespDelay;
    end
  // ----------------------------------------
  // Straps and interrupt routing
  // ----------------------------------------
  logic [2:0] strapQ;
  logic [1:0] strapWait_ff;
  wlhssp_sync #(.WIDTH(3)) u_strapSync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (strapIfc),
    .q     (strapQ)
  );
  // Caught once, after the synchroniser has filled
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      strapWait_ff <= 2'h0;
      spiModeEn    <= 1'b0;
    end
    else if (strapWait_ff != 2'h3)
    begin
      strapWait_ff <= strapWait_ff + 2'h1;
      if (strapWait_ff == 2'h2)
        spiModeEn <= (strapQ == STRAP_SPI);
    end
  // Interrupt to its own line or to the general-purpose pin
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      hostIrq <= 1'b0;
      gpioIrq <= 1'b0;
    end
    else
    begin
      hostIrq <= ~irqPol_ff ^ (devIrq & ~irqGpio_ff);
      gpioIrq <= ~irqPol_ff ^ (devIrq & irqGpio_ff);
    end
  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic [31:0] rdHold_ff, stHold_ff;
  logic        ackTgl_ff;
  logic [14:0] linkQ;
  logic        lWide, lBig, lHiSpd, lStEn, lDlyAll, lMode, ackSync;
  logic [7:0]  lRespDly;
  // Static settings; change them only between frames
  wlhssp_sync #(.WIDTH(15)) u_linkSync (
    .clk   (spiClk),
    .rst_b (rst_b),
    .d     ({ackTgl_ff, spiModeEn, respDelay_ff, delayAll_ff, statEn_ff, hiSpeed_ff, bigEnd_ff, wordLen_ff}),
    .q     (linkQ)
  );
  assign {ackSync, lMode, lRespDly, lDlyAll, lStEn, lHiSpd, lBig, lWide} = linkQ;
  // Frame state ends with the frame itself
  wire frameRst_b = rst_b & ~spiCs_b;
  wlhssp_pkg::wlhssp_phase_t phase_ff;
  logic [4:0]  bitCnt_ff;
  logic [30:0] rxShift_ff;
  logic        firstEdge_ff, armed_ff;
  logic [9:0]  wordsLeft_ff;
  logic [10:0] delayLeft_ff;
  logic [16:0] addr_ff, reqAddr_ff, wrAd_ff;
  logic [1:0]  func_ff;
  logic        incr_ff, reqRd_ff, reqTgl_ff, wrTgl_ff;
  logic        notAvail_ff, under_ff, over_ff;
  logic [31:0] txShift_ff, wrWord_ff;
  logic        sdoFall_ff;
  // Command decode of the word completing at this edge
  wire [31:0] rxWord   = {rxShift_ff, serial_data_in};
  wire        wordDone = (bitCnt_ff == 5'h1f);
  wire [31:0] cmdRx    = wlhssp_pkg::wlhssp_swz(rxWord, lBig, lWide);
  wire        cmdWr    = cmdRx[`WLHSSP_CMD_WR_BIT];
  wire [1:0]  cmdFn    = cmdRx[`WLHSSP_CMD_FN_HI:`WLHSSP_CMD_FN_LO];
  wire [16:0] cmdAd    = cmdRx[`WLHSSP_CMD_AD_HI:`WLHSSP_CMD_AD_LO];
  logic [11:0] cmdBytes, fnLim, useBytes;
  logic [9:0]  cmdWords;
  logic        overLim;
  // Byte count, zero meaning a full frame, clipped to the function's limit
  always_comb
  begin
    cmdBytes = (cmdRx[`WLHSSP_CMD_LN_HI:`WLHSSP_CMD_LN_LO] == 11'h000) ? FRAME_LIM :
               {1'b0, cmdRx[`WLHSSP_CMD_LN_HI:`WLHSSP_CMD_LN_LO]};
    unique case (cmdFn)
      wlhssp_pkg::FN_CTRL: fnLim = `WLHSSP_CTRL_MAX;
      wlhssp_pkg::FN_BKPL: fnLim = `WLHSSP_BKPL_MAX;
      wlhssp_pkg::FN_PKT:  fnLim = `WLHSSP_PKT_MAX;
      wlhssp_pkg::FN_RSVD: fnLim = FRAME_LIM;
    endcase
    overLim  = (cmdBytes > fnLim);
    useBytes = overLim ? fnLim : cmdBytes;
    cmdWords = 10'((useBytes + 12'h003) >> 2);
  end
  // Delay applies to backplane reads, or to all reads when so set
  wire        dlyUse   = lDlyAll | (cmdFn == wlhssp_pkg::FN_BKPL);
  wire [10:0] dlyBits  = dlyUse ? {lRespDly, 3'h0} : 11'h000;
  wire        armGo    = armed_ff & firstEdge_ff & (phase_ff == wlhssp_pkg::PH_CMD);
  wire        evCmd    = lMode & ~armGo & wordDone & (phase_ff == wlhssp_pkg::PH_CMD);
  wire        inData   = (phase_ff == wlhssp_pkg::PH_WDATA) | (phase_ff == wlhssp_pkg::PH_RDATA);
  wire        lastWord = (wordsLeft_ff == 10'h001);
  wire        evDlyEnd = (phase_ff == wlhssp_pkg::PH_DELAY) & (delayLeft_ff == 11'h000);
  wire        evRdNext = (phase_ff == wlhssp_pkg::PH_RDATA) & wordDone & ~lastWord;
  wire        evLoad   = armGo | evDlyEnd | evRdNext | (evCmd & ~cmdWr & (dlyBits == 11'h000));
  wire        evStat   = inData & wordDone & lastWord & lStEn;
  wire        evWrWord = (phase_ff == wlhssp_pkg::PH_WDATA) & wordDone;
  wire        dataOk   = armGo | ((ackSync == reqTgl_ff) & ~evCmd);
  wire [31:0] dataWire = dataOk ? wlhssp_pkg::wlhssp_swz(rdHold_ff, lBig, lWide) : 32'h0000_0000;
  wire [31:0] stWord   = {stHold_ff[31:3], over_ff, under_ff, notAvail_ff};
  wire [9:0]  loadRem  = evCmd ? cmdWords : (evRdNext ? wordsLeft_ff - 10'h001 : wordsLeft_ff);
  wire        evReq    = evCmd | (evLoad & (loadRem > 10'h001));
  // Address of the word after the current one
  wire [16:0] addrNext = addr_ff + (incr_ff ? 17'h00004 : 17'h00000);
  // Phase sequence; receive always on the rising, active edge
  always_ff @(posedge spiClk or negedge frameRst_b)
    if (!frameRst_b)
    begin
      phase_ff     <= wlhssp_pkg::PH_CMD;
      bitCnt_ff    <= 5'h00;
      rxShift_ff   <= 31'h0;
      firstEdge_ff <= 1'b1;
    end
    else
    begin
      firstEdge_ff <= 1'b0;
      rxShift_ff   <= rxWord[30:0];
      bitCnt_ff    <= bitCnt_ff + 5'h01;
      if (!lMode)
        phase_ff <= wlhssp_pkg::PH_IDLE;
      else
        unique case (phase_ff)
          wlhssp_pkg::PH_CMD:
            if (armGo)
            begin
              phase_ff  <= wlhssp_pkg::PH_RDATA;
              bitCnt_ff <= 5'h01;
            end
            else if (wordDone)
              phase_ff <= cmdWr ? wlhssp_pkg::PH_WDATA :
                          (dlyBits != 11'h000) ? wlhssp_pkg::PH_DELAY : wlhssp_pkg::PH_RDATA;
          wlhssp_pkg::PH_WDATA, wlhssp_pkg::PH_RDATA:
            if (wordDone && lastWord)
              phase_ff <= lStEn ? wlhssp_pkg::PH_STATUS : wlhssp_pkg::PH_IDLE;
          wlhssp_pkg::PH_DELAY:
          begin
            bitCnt_ff <= 5'h00;
            if (delayLeft_ff == 11'h000)
              phase_ff <= wlhssp_pkg::PH_RDATA;
          end
          wlhssp_pkg::PH_STATUS:
            if (wordDone)
              phase_ff <= wlhssp_pkg::PH_IDLE;
          wlhssp_pkg::PH_IDLE:
            bitCnt_ff <= 5'h00;
          default:
            phase_ff <= wlhssp_pkg::PH_IDLE;
        endcase
    end
  // Transaction context survives the select gap of a standalone read
  always_ff @(posedge spiClk or negedge rst_b)
    if (!rst_b)
    begin
      armed_ff     <= 1'b0;
      wordsLeft_ff <= 10'h000;
      delayLeft_ff <= 11'h000;
      addr_ff      <= 17'h0;
      func_ff      <= 2'h0;
      incr_ff      <= 1'b0;
      under_ff     <= 1'b0;
      over_ff      <= 1'b0;
      notAvail_ff  <= 1'b0;
    end
    else
    begin
      armed_ff    <= evCmd & ~cmdWr;
      notAvail_ff <= (notAvail_ff & ~evCmd) | (evLoad & ~dataOk);
      if (evCmd)
      begin
        wordsLeft_ff <= cmdWords;
        delayLeft_ff <= dlyBits - 11'h001;
        addr_ff      <= cmdAd;
        func_ff      <= cmdFn;
        incr_ff      <= cmdRx[`WLHSSP_CMD_INC_BIT];
        under_ff     <= ~cmdWr & overLim;
        over_ff      <= cmdWr & overLim;
      end
      else
      begin
        if (phase_ff == wlhssp_pkg::PH_DELAY)
          delayLeft_ff <= delayLeft_ff - 11'h001;
        if (inData && wordDone)
          wordsLeft_ff <= wordsLeft_ff - 10'h001;
        if ((evReq && !evCmd) || evWrWord)
          addr_ff <= addrNext;
      end
    end
  // Requests and write words cross by toggle; payload holds for a word time
  always_ff @(posedge spiClk or negedge rst_b)
    if (!rst_b)
    begin
      reqTgl_ff  <= 1'b0;
      reqRd_ff   <= 1'b0;
      reqAddr_ff <= 17'h0;
      wrTgl_ff   <= 1'b0;
      wrWord_ff  <= 32'h0000_0000;
      wrAd_ff    <= 17'h0;
    end
    else
    begin
      if (evReq)
      begin
        reqTgl_ff  <= ~reqTgl_ff;
        reqRd_ff   <= evCmd ? ~cmdWr : 1'b1;
        reqAddr_ff <= evCmd ? cmdAd : addrNext;  // Prefetch is one word ahead
      end
      if (evWrWord)
      begin
        wrTgl_ff  <= ~wrTgl_ff;
        wrAd_ff   <= addr_ff;  // Held: addr_ff moves on at this edge
        wrWord_ff <= wlhssp_pkg::wlhssp_swz(rxWord, lBig, lWide);
      end
    end
  // Transmit shifter, loaded on the last delay edge
  always_ff @(posedge spiClk or negedge rst_b)
    if (!rst_b)
      txShift_ff <= 32'h0000_0000;
    else if (evLoad)
      txShift_ff <= armGo ? {dataWire[30:0], 1'b0} : dataWire;
    else if (evStat)
      txShift_ff <= wlhssp_pkg::wlhssp_swz(stWord, lBig, lWide);
    else
      txShift_ff <= {txShift_ff[30:0], 1'b0};
  // Normal mode launches on the falling edge
  always_ff @(negedge spiClk or negedge rst_b)
    if (!rst_b)
      sdoFall_ff <= 1'b0;
    else
      sdoFall_ff <= txShift_ff[31];
  // First standalone bit comes straight from the held word
  wire firstUse = armed_ff & firstEdge_ff;
  wire txPhase  = (phase_ff == wlhssp_pkg::PH_DELAY) | (phase_ff == wlhssp_pkg::PH_RDATA) |
                  (phase_ff == wlhssp_pkg::PH_STATUS);
  assign spiSdo   = firstUse ? dataWire[31] : (lHiSpd ? txShift_ff[31] : sdoFall_ff);
  assign spiSdoOe = ~spiCs_b & lMode & (txPhase | firstUse);
  // ----------------------------------------
  // System side of the crossing
  // ----------------------------------------
  logic [1:0] tglQ;
  logic       reqSeen_ff, wrSeen_ff;
  logic [1:0] ansPend_ff;
  wlhssp_sync #(.WIDTH(2)) u_sysSync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     ({reqTgl_ff, wrTgl_ff}),
    .q     (tglQ)
  );
  wire reqEdge = tglQ[1] ^ reqSeen_ff;
  wire wrEdge  = tglQ[0] ^ wrSeen_ff;
  // Read request out, answer caught two cycles later
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      reqSeen_ff <= 1'b0;
      ansPend_ff <= 2'h0;
      rdReq      <= 1'b0;
      rdAddr     <= 17'h0;
      rdFunc     <= 2'h0;
      rdHold_ff  <= 32'h0000_0000;
      stHold_ff  <= 32'h0000_0000;
      ackTgl_ff  <= 1'b0;
    end
    else
    begin
      reqSeen_ff <= tglQ[1];
      ansPend_ff <= {ansPend_ff[0], reqEdge};
      rdReq      <= reqEdge & reqRd_ff;
      if (reqEdge)
      begin
        rdAddr <= reqAddr_ff;
        rdFunc <= func_ff;
      end
      if (ansPend_ff[1])
      begin
        rdHold_ff <= rdData;
        stHold_ff <= statusIn;
        ackTgl_ff <= ~ackTgl_ff;
      end
    end
  // Packet function words go to the DMA path
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      wrSeen_ff  <= 1'b0;
      wrValid    <= 1'b0;
      dmaWrValid <= 1'b0;
      wrAddr     <= 17'h0;
      wrFunc     <= 2'h0;
      wrData     <= 32'h0000_0000;
    end
    else
    begin
      wrSeen_ff  <= tglQ[0];
      wrValid    <= wrEdge & (func_ff != wlhssp_pkg::FN_PKT);
      dmaWrValid <= wrEdge & (func_ff == wlhssp_pkg::FN_PKT);
      if (wrEdge)
      begin
        wrAddr <= wrAd_ff;
        wrFunc <= func_ff;
        wrData <= wrWord_ff;
      end
    end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence sDelayEnd;
    phase_ff == wlhssp_pkg::PH_DELAY && delayLeft_ff == 11'h000;
  endsequence
  sequence sDataStart;
    phase_ff == wlhssp_pkg::PH_RDATA && bitCnt_ff == 5'h00;
  endsequence
  cfg_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> respDelay_ff == `WLHSSP_RDLY_RST) else $error("response delay reset wrong");
  word_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> !wordLen_ff && !bigEnd_ff) else $error("word format reset wrong");
  out_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    spiCs_b |-> !spiSdoOe) else $error("data out driven while deselected");
  cmd_word_a: assert property (@(posedge spiClk) disable iff (!frameRst_b)
    (phase_ff == wlhssp_pkg::PH_CMD && !wordDone && !armGo && lMode) |=> phase_ff == wlhssp_pkg::PH_CMD)
    else $error("command ended early");
  delay_count_a: assert property (@(posedge spiClk) disable iff (!frameRst_b)
    (phase_ff == wlhssp_pkg::PH_DELAY && delayLeft_ff != 11'h000 && lMode) |=>
    phase_ff == wlhssp_pkg::PH_DELAY && delayLeft_ff == $past(delayLeft_ff) - 11'h001)
    else $error("delay count broken");
  data_launch_a: assert property (@(posedge spiClk) disable iff (!frameRst_b)
    (sDelayEnd and lMode) |=> sDataStart) else $error("data not launched after delay");
  status_len_a: assert property (@(posedge spiClk) disable iff (!frameRst_b)
    (phase_ff == wlhssp_pkg::PH_STATUS && !wordDone && lMode) |=> phase_ff == wlhssp_pkg::PH_STATUS)
    else $error("status word cut short");
  rd_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(rdReq) |-> ##2 ackTgl_ff != $past(ackTgl_ff, 2) ##0 rdHold_ff == $past(rdData))
    else $error("read answer not captured");
  dma_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    dmaWrValid |-> wrFunc == wlhssp_pkg::FN_PKT && !wrValid) else $error("packet word misrouted");
  irq_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (devIrq && irqGpio_ff && irqPol_ff) |=> gpioIrq && !hostIrq) else $error("interrupt not on pin");
  strap_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (strapWait_ff == 2'h2) |=> spiModeEn == ($past(strapQ) == STRAP_SPI)) else $error("strap mode wrong");
endmodule // wlhssp_port
`default_nettype wire

// >>> wlhssp_host.sv
`default_nettype none
module wlhssp_host (
  // Link pins
  output var  logic sclk,
  output var  logic csB,
  output var  logic sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock parked low, select high until a frame starts
  initial
  begin
    sclk = 1'b0;
    csB  = 1'b1;
    sdi  = 1'b0;
  end
  // One frame, tx MSB first; 32 ns bit time keeps under the top rate
  task automatic frame(input logic [127:0] tx, input int nb, output logic [127:0] rx);
    rx  = '0;
    csB = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      sdi = tx[127-i];
      #15;
      rx[127-i] = sdo;
      #1 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 csB = 1'b1;
    sdi = ~sdi;                // Inverted: no stale level
    #32;                       // Deselect gap before the next frame
  endtask
endmodule // wlhssp_host
`default_nettype wire

// >>> wlan_host_serial_slave_port_test.sv
`default_nettype none
module wlan_host_serial_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
  // ----
  // Signals
  // ----
  logic         sys_clk, rst_b, sclk, csB, sdi, sdo, sdoOe, modeEn, cfgWr, wl, be, hs, dAll, gp;
  logic         devIrq, hostIrq, gpioIrq, wrValid, dmaWrValid, gotDma, ip, rdReq;
  logic [1:0]   wrFunc, rdFunc, gotF, gotRf;
  logic [7:0]   dly;
  logic [16:0]  rdAddr, wrAddr, gotA, a;
  logic [31:0]  rdData, wrData, gotD, statIn, d;
  logic [127:0] junk;
  int           err_count, tests_run, nW;
  wire          sdoLine = sdoOe ? sdo : 1'bz;
  // Read data follows the requested address
  assign rdData = expRd(rdAddr);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  wlhssp_host i_host (.sclk(sclk), .csB(csB), .sdi(sdi), .sdo(sdoLine));
  wlhssp_port i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .spiClk(sclk), .spiCs_b(csB), .serial_data_in(sdi), .spiSdo(sdo),
    .spiSdoOe(sdoOe), .strapIfc(3'h1), .spiModeEn(modeEn), .cfgWr(cfgWr), .cfgWordLen(wl), .cfgBigEnd(be),
    .cfgHiSpeed(hs), .cfgIrqPol(ip), .cfgStatEn(1'b1), .cfgDelayAll(dAll), .cfgIrqGpio(gp), .cfgRespDelay(dly),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdFunc(rdFunc), .rdData(rdData), .statusIn(statIn), .wrValid(wrValid),
    .dmaWrValid(dmaWrValid), .wrAddr(wrAddr), .wrFunc(wrFunc), .wrData(wrData), .devIrq(devIrq),
    .hostIrq(hostIrq), .gpioIrq(gpioIrq));
  // Latest write word seen on the system side
  always @(posedge sys_clk)
    if (wrValid | dmaWrValid)
    begin
      nW     <= nW + 1;
      gotD   <= wrData;
      gotA   <= wrAddr;
      gotDma <= dmaWrValid;
      gotF   <= wrFunc;
    end
  // Function of the latest read request
  always @(posedge sys_clk)
    if (rdReq)
      gotRf <= rdFunc;
  // ----
  // Expectations
  // ----
  function automatic logic [31:0] expRd(logic [16:0] x);
    return {x[15:0], ~x[15:0]};
  endfunction
  // Word to wire order; applying it twice gives the word back
  function automatic logic [31:0] wfmt(logic [31:0] w);
    if (be)
      return w;
    return wl ? {w[7:0], w[15:8], w[23:16], w[31:24]} : {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction
  function automatic logic [31:0] cmd(logic wr, logic [1:0] f, logic [16:0] x);
    return wfmt({wr, 1'b0, f, x, 11'h004});
  endfunction
  // ----
  // Tasks
  // ----
  task automatic setCfg(logic w, logic b, logic h, logic al, logic g, logic [7:0] dy);
    @(posedge sys_clk);
    #2 {wl, be, hs, dAll, gp, dly, cfgWr} = {w, b, h, al, g, dy, 1'b1};
    @(posedge sys_clk);
    #2 cfgWr = 1'b0;
    i_host.frame('0, 16, junk); // Short frame lets the link pick up the change
  endtask
  task automatic wrChk(logic [1:0] f);
    logic [127:0] rx;
    logic [31:0]  st;
    int           n0;
    n0 = nW;
    a  = 17'($urandom);
    d  = $urandom;
    i_host.frame({cmd(1'b1, f, a), wfmt(d), 64'h0}, 96, rx);
    for (int k = 0; k < 40 && nW == n0; k++)
      @(posedge sys_clk);
    st = wfmt(rx[63:32]); // Status follows the single data word
    `CHK("wrData", d, gotD)
    `CHK("wrAddr", a, gotA)
    `CHK("dmaPath", f == 2'h2, gotDma)
    `CHK("wrFunc", f, gotF)
    `CHK("wrStatus", {statIn[31:3], 3'h0}, st)
  endtask
  task automatic rdChk(logic [1:0] f, int dl, logic na);
    logic [127:0] rx;
    logic [31:0]  st, dw, ex;
    a  = 17'($urandom);
    ex = na ? 32'h0 : expRd(a);
    i_host.frame({cmd(1'b0, f, a), 96'h0}, 96 + dl, rx);
    dw = wfmt(rx[95-dl -: 32]);
    st = wfmt(rx[63-dl -: 32]);
    `CHK("delayBits", 32'h0, dl ? rx[95:64] : 32'h0)
    `CHK("rdData", ex, dw)
    `CHK("notAvail", na, st[0])
    `CHK("rdFunc", f, gotRf)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far beyond the twenty frames below
  initial
  begin
    #500000;
    err_count++;
    complete_run();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    {rst_b, cfgWr, wl, be, hs, dAll, gp, dly, devIrq, ip} = {7'h04, 8'h04, 2'h1};
    {err_count, tests_run, nW} = '0;
    void'($urandom(58));
    statIn = $urandom;
    repeat (16) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    repeat (6) @(posedge sys_clk);
    i_host.frame('0, 16, junk);
    `CHK("modeEn", 1'b1, modeEn)
    `CHK("sdoOff", 1'b0, sdoOe)
    wrChk(2'h1);
    setCfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h04);
    wrChk(2'h2);
    rdChk(2'h1, 32, 1'b0);
    for (int h = 0; h < 2; h++)
    begin
      setCfg(1'b1, 1'b0, h[0], 1'b1, 1'b0, 8'h04);
      for (int f = 0; f < 3; f++)
        rdChk(f[1:0], 32, 1'b0);
    end
    wrChk(2'h1);
    i_host.frame({cmd(1'b0, 2'h1, a), 96'h0}, 32, junk);
    #1000;
    i_host.frame('0, 64, junk);
    `CHK("standalone", expRd(a), wfmt(junk[127:96]))
    setCfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    rdChk(2'h1, 0, 1'b1);
    @(posedge sys_clk);
    #2 devIrq = 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("hostIrq", 1'b1, hostIrq)
    setCfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h04);
    `CHK("gpioIrq", 1'b1, gpioIrq)
    `CHK("hostIrqOff", 1'b0, hostIrq)
    @(posedge sys_clk);
    #2 ip = 1'b0;
    setCfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h04);
    `CHK("gpioIrqLow", 1'b0, gpioIrq)
    `CHK("hostIrqIdle", 1'b1, hostIrq)
    complete_run();
  end
endmodule // wlan_host_serial_slave_port_test
`default_nettype wire
